/* File: dcff_pkg.sv */
// dcff_pkg: constants and carrier types for the dual-port fifo with flags
package dcff_pkg;

  localparam int DATA_W      = 18;
  localparam int DEF_DEPTH   = 131072;
  localparam int OFF_W       = 17;
  localparam int SYNC_STAGES = 2;

  // default offsets chosen by the load select level at master reset
  localparam logic [OFF_W-1:0] OFF_DEF_PAR = 17'h0007F;
  localparam logic [OFF_W-1:0] OFF_DEF_SER = 17'h003FF;

  // mclk cycles the full and empty flags are held after a rewind
  localparam logic [1:0] REWIND_HOLD = 2'h3;

  typedef struct packed {
    logic fallThroughTiming;
    logic serialProg;
  } dcff_cfg_t;

  localparam dcff_cfg_t CFG_RESET = '{fallThroughTiming: 1'b0, serialProg: 1'b0};

  // all flags active low at the pins
  typedef struct packed {
    logic fullSpaceFlag;
    logic emptyValidFlag;
    logic almostFullFlag;
    logic almostEmptyFlag;
    logic halfFullFlag;
  } dcff_flags_t;

endpackage

/* File: dcff_gray_sync.sv */
// dcff_gray_sync: multi-stage synchroniser for a gray-coded pointer
`timescale 1ns/1ns
module dcff_gray_sync #(
  parameter int W      = 18,
  parameter int STAGES = 2
)(
  input  wire logic         mclk,
  input  wire logic         clear,
  input  wire logic [W-1:0] grayIn,
  output logic      [W-1:0] grayOut
);

  logic [W-1:0] stage_r [STAGES];

  // first stage feeds only the second; clear keeps stale pointers out after reset
  always_ff @(posedge mclk)
  begin
    if (clear)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_r[i] <= '0;
    end
    else
    begin
      stage_r[0] <= grayIn;
      for (int i = 1; i < STAGES; i++)
        stage_r[i] <= stage_r[i-1];
    end
  end

  assign grayOut = stage_r[STAGES-1];

endmodule // dcff_gray_sync

/* File: dcff_fifo.sv */
// dcff_fifo: deep fifo with standard and fall-through timing, offsets and flags
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module dcff_fifo #(
  parameter int DEPTH = dcff_pkg::DEF_DEPTH
)(
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        writeClock,
  input  wire logic                        readClock,
  input  wire logic [dcff_pkg::DATA_W-1:0] writeDataBus,
  input  wire logic                        writeEnable_n,
  input  wire logic                        readEnable_n,
  input  wire logic                        serialEnable_n,
  input  wire logic                        loadSelect_n,
  input  wire logic                        modePickBitInput,
  input  wire logic                        masterReset_n,
  input  wire logic                        partialReset_n,
  input  wire logic                        rewindRead_n,
  input  wire logic                        outputEnable_n,
  output logic      [dcff_pkg::DATA_W-1:0] readDataBus,
  output logic                             readDataDrive,
  output dcff_pkg::dcff_flags_t            flags_n
);

  import dcff_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_CNT = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_CNT  = PW'(DEPTH / 2);

  // binary to gray: one bit changes per increment
  function automatic logic [PW-1:0] toGray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // gray back to binary, msb first
  function automatic logic [PW-1:0] fromGray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  logic              writeClockPrev_r;
  logic              readClockPrev_r;
  logic              writeEdge;
  logic              readEdge;
  logic              ptrClear;
  dcff_cfg_t         cfg_r;
  logic [OFF_W-1:0]  emptyOffset_r;
  logic [OFF_W-1:0]  fullOffset_r;
  logic              offWriteSel_r;
  logic              offReadSel_r;
  logic [PW-1:0]     wrBin_r;
  logic [PW-1:0]     wrBin_nxt;
  logic [PW-1:0]     wrGray_r;
  logic [PW-1:0]     rdBin_r;
  logic [PW-1:0]     rdBin_nxt;
  logic [PW-1:0]     rdGray_r;
  logic [PW-1:0]     rdGraySync;
  logic [PW-1:0]     wrGraySync;
  logic [PW-1:0]     wrCount;
  logic [PW-1:0]     rdCount;
  logic [PW-1:0]     rdLevel;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] readDataBus_r;
  logic              outValid_r;
  logic [1:0]        rewindHold_r;
  logic              rdHold;
  logic              fullW;
  logic              emptyR;
  logic              wrAccept;
  logic              parWrite;
  logic              serShift;
  logic              offRead;
  logic              rewindReq;
  logic              stdRead;
  logic              consume;
  logic              fetch;
  logic              memRead;

  // port clocks arrive synchronous to mclk; a rising level marks a port edge
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      writeClockPrev_r <= 1'b0;
      readClockPrev_r  <= 1'b0;
    end
    else
    begin
      writeClockPrev_r <= writeClock;
      readClockPrev_r  <= readClock;
    end
  end

  assign writeEdge = writeClock & ~writeClockPrev_r;
  assign readEdge  = readClock & ~readClockPrev_r;

  // either reset pin clears pointers and output; rst also resets configuration and offsets, but not the memory
  assign ptrClear = rst | ~masterReset_n | ~partialReset_n;

  // configuration only moves while master reset is held
  always_ff @(posedge mclk)
  begin
    if (rst)
      cfg_r <= CFG_RESET;
    else if (!masterReset_n)
    begin
      cfg_r.fallThroughTiming <= modePickBitInput;
      cfg_r.serialProg        <= loadSelect_n;
    end
  end

  // write port decode
  assign fullW    = (wrCount == DEPTH_CNT) | rdHold;
  assign wrAccept = writeEdge & ~writeEnable_n & loadSelect_n & ~fullW & ~ptrClear;
  assign parWrite = writeEdge & ~writeEnable_n & ~loadSelect_n & ~cfg_r.serialProg
                    & ~ptrClear;
  assign serShift = writeEdge & ~serialEnable_n & ~loadSelect_n & cfg_r.serialProg
                    & ~ptrClear;
  assign wrBin_nxt = wrBin_r + {{(PW-1){1'b0}}, wrAccept};

  // data memory: no reset, contents survive both reset pins
  always_ff @(posedge mclk)
  begin
    if (wrAccept)
      mem[wrBin_r[AW-1:0]] <= writeDataBus;
  end

  // write pointer with its gray copy for the read side
  always_ff @(posedge mclk)
  begin
    if (ptrClear)
    begin
      wrBin_r  <= '0;
      wrGray_r <= '0;
    end
    else
    begin
      wrBin_r  <= wrBin_nxt;
      wrGray_r <= toGray(wrBin_nxt);
    end
  end

  // offset registers: defaults at master reset, kept across partial reset.
  // serial chain runs empty offset lsb first toward full offset msb
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      emptyOffset_r <= OFF_DEF_PAR;
      fullOffset_r  <= OFF_DEF_PAR;
      offWriteSel_r <= 1'b0;
      offReadSel_r  <= 1'b0;
    end
    else if (!masterReset_n)
    begin
      emptyOffset_r <= loadSelect_n ? OFF_DEF_SER : OFF_DEF_PAR;
      fullOffset_r  <= loadSelect_n ? OFF_DEF_SER : OFF_DEF_PAR;
      offWriteSel_r <= 1'b0;
      offReadSel_r  <= 1'b0;
    end
    else if (!partialReset_n)
    begin
      offWriteSel_r <= 1'b0;
      offReadSel_r  <= 1'b0;
    end
    else
    begin
      if (parWrite)
      begin
        if (offWriteSel_r)
          fullOffset_r <= writeDataBus[OFF_W-1:0];
        else
          emptyOffset_r <= writeDataBus[OFF_W-1:0];
        offWriteSel_r <= ~offWriteSel_r;
      end
      else if (serShift)
      begin
        {fullOffset_r, emptyOffset_r} <= {fullOffset_r[OFF_W-2:0], emptyOffset_r,
                                          modePickBitInput};
      end
      if (offRead)
        offReadSel_r <= ~offReadSel_r;
    end
  end

  // pointers cross through gray synchronisers so flags err on the safe side
  dcff_gray_sync #(
    .W      (PW),
    .STAGES (SYNC_STAGES)
  ) uRdToWr (
    .mclk    (mclk),
    .clear   (ptrClear),
    .grayIn  (rdGray_r),
    .grayOut (rdGraySync)
  );

  dcff_gray_sync #(
    .W      (PW),
    .STAGES (SYNC_STAGES)
  ) uWrToRd (
    .mclk    (mclk),
    .clear   (ptrClear),
    .grayIn  (wrGray_r),
    .grayOut (wrGraySync)
  );

  // fill levels as seen from each side; both lag the far pointer
  assign wrCount = wrBin_r - fromGray(rdGraySync);
  assign rdCount = fromGray(wrGraySync) - rdBin_r;
  assign rdLevel = rdCount + {{(PW-1){1'b0}}, outValid_r & cfg_r.fallThroughTiming};
  assign emptyR  = (rdCount == '0);
  assign rdHold  = (rewindHold_r != 2'h0);

  // read port decode; rewind beats a read in the same edge
  assign rewindReq = readEdge & ~rewindRead_n & ~ptrClear;
  assign offRead   = readEdge & ~readEnable_n & ~loadSelect_n & ~ptrClear;
  assign stdRead   = ~cfg_r.fallThroughTiming & readEdge & ~readEnable_n & loadSelect_n
                     & ~emptyR & ~rdHold & ~rewindReq & ~ptrClear;
  assign consume   = readEdge & ~readEnable_n & loadSelect_n & outValid_r;
  // fall-through refills the output register on its own, no read enable needed
  assign fetch     = cfg_r.fallThroughTiming & readEdge & ~emptyR & ~rdHold & ~rewindReq
                     & ~offRead & ~ptrClear & (~outValid_r | consume);
  assign memRead   = stdRead | fetch;
  assign rdBin_nxt = rewindReq ? '0 : rdBin_r + {{(PW-1){1'b0}}, memRead};

  // read pointer; write pointer is never touched by a rewind
  always_ff @(posedge mclk)
  begin
    if (ptrClear)
    begin
      rdBin_r  <= '0;
      rdGray_r <= '0;
    end
    else
    begin
      rdBin_r  <= rdBin_nxt;
      rdGray_r <= toGray(rdBin_nxt);
    end
  end

  // output register: words from memory, offsets while load select is low
  always_ff @(posedge mclk)
  begin
    if (ptrClear)
      readDataBus_r <= '0;
    else if (memRead)
      readDataBus_r <= mem[rdBin_r[AW-1:0]];
    else if (offRead)
      readDataBus_r <= offReadSel_r ? DATA_W'(fullOffset_r) : DATA_W'(emptyOffset_r);
  end

  // fall-through: a valid word sits on the bus until a read consumes it
  always_ff @(posedge mclk)
  begin
    if (ptrClear)
      outValid_r <= 1'b0;
    else if (rewindReq)
      outValid_r <= 1'b0;
    else if (fetch)
      outValid_r <= 1'b1;
    else if (consume)
      outValid_r <= 1'b0;
  end

  // hold covers the synchroniser delay so the write side never sees stale
  // read pointer after a rewind; trades a few blocked cycles for safety
  always_ff @(posedge mclk)
  begin
    if (ptrClear)
      rewindHold_r <= 2'h0;
    else if (rewindReq)
      rewindHold_r <= REWIND_HOLD;
    else if (rdHold)
      rewindHold_r <= rewindHold_r - 2'h1;
  end

  // flags, all active low at the pins
  always_comb
  begin
    flags_n.fullSpaceFlag   = cfg_r.fallThroughTiming ? fullW : ~fullW;
    if (rdHold)
      flags_n.emptyValidFlag = cfg_r.fallThroughTiming;
    else if (cfg_r.fallThroughTiming)
      flags_n.emptyValidFlag = ~outValid_r;
    else
      flags_n.emptyValidFlag = ~emptyR;
    flags_n.almostFullFlag  = ~(wrCount > (DEPTH_CNT - PW'(fullOffset_r)));
    flags_n.almostEmptyFlag = ~(rdLevel < PW'(emptyOffset_r));
    flags_n.halfFullFlag    = ~(wrCount > HALF_CNT);
  end

  // read bus comes straight from the output register
  assign readDataBus   = readDataBus_r;
  assign readDataDrive = ~outputEnable_n;

  // checks
  default clocking cbMain @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence sRewind;
    readEdge && !rewindRead_n && masterReset_n && partialReset_n;
  endsequence

  sequence sRewindDone;
    (rdBin_r == '0) && (flags_n.emptyValidFlag == cfg_r.fallThroughTiming);
  endsequence

  sequence sFallIdle;
    cfg_r.fallThroughTiming && !outValid_r && !emptyR && !rdHold && !ptrClear;
  endsequence

  a_mrs_clears_ptrs: assert property (
    !masterReset_n |=> (wrBin_r == '0) && (rdBin_r == '0) && (readDataBus == '0))
    else $error("master reset left a pointer or output nonzero");

  a_cfg_latch_mode: assert property (
    !masterReset_n |=> cfg_r.fallThroughTiming == $past(modePickBitInput))
    else $error("timing mode not taken from the mode pin");

  a_prs_keeps_cfg: assert property (
    masterReset_n && !partialReset_n |=> (cfg_r == $past(cfg_r))
      && (emptyOffset_r == $past(emptyOffset_r)) && (wrBin_r == '0))
    else $error("partial reset disturbed settings or kept pointer");

  a_rewind_ptr_flag: assert property (
    sRewind |=> sRewindDone ##0 (wrBin_r >= $past(wrBin_r)))
    else $error("rewind did not zero read pointer or force flag");

  a_rewind_hold_len: assert property (
    sRewind ##1 (masterReset_n && partialReset_n)[*3] |=> !rdHold)
    else $error("rewind hold lasted longer than expected");

  a_default_offset: assert property (
    !masterReset_n && loadSelect_n |=> (emptyOffset_r == OFF_DEF_SER)
      && (fullOffset_r == OFF_DEF_SER) && cfg_r.serialProg)
    else $error("serial default offset not selected");

  a_serial_shift_bit: assert property (
    serShift |=> (emptyOffset_r[0] == $past(modePickBitInput))
      && (emptyOffset_r[OFF_W-1:1] == $past(emptyOffset_r[OFF_W-2:0])))
    else $error("serial shift did not move exactly one bit");

  a_full_blocks_wr: assert property (
    fullW && !ptrClear |=> wrBin_r == $past(wrBin_r))
    else $error("write accepted while full");

  a_std_read_gate: assert property (
    !cfg_r.fallThroughTiming && !ptrClear && !(readEdge && !readEnable_n)
      |=> $stable(readDataBus))
    else $error("standard mode output changed without a read");

  a_fall_through_fill: assert property (
    (readEdge && rewindRead_n && loadSelect_n) ##0 sFallIdle
      |=> outValid_r && !flags_n.emptyValidFlag)
    else $error("fall-through word did not appear on its own");

endmodule // dcff_fifo

/* File: dcff_port_model.sv */
// dcff_port_model: writing and reading logic that drive the fifo pins
`timescale 1ns/1ns
module dcff_port_model (
  input  wire logic                 mclk,
  output logic                      writeClock,
  output logic                      readClock,
  output logic [dcff_pkg::DATA_W-1:0] writeDataBus,
  output logic                      writeEnable_n,
  output logic                      readEnable_n,
  output logic                      serialEnable_n,
  output logic                      loadSelect_n,
  output logic                      modePickBitInput,
  output logic                      masterReset_n,
  output logic                      partialReset_n,
  output logic                      rewindRead_n
);
  import dcff_pkg::*;

  // idle levels; port clocks stand still low outside transfers
  initial
  begin
    {writeClock, readClock, modePickBitInput} = 3'h0;
    {writeEnable_n, readEnable_n, serialEnable_n, loadSelect_n} = 4'hF;
    {masterReset_n, partialReset_n, rewindRead_n} = 3'h7;
    writeDataBus = 18'h00000;
  end

  // one write edge; released data and serial-in lines show the inverse so stale data never passes, enables return high
  task automatic wr(input logic [DATA_W-1:0] d, input logic wen, input logic serial_enable,
                    input logic ld, input logic si);
    @(posedge mclk);
    writeDataBus     <= d;
    writeEnable_n    <= wen;
    serialEnable_n   <= serial_enable;
    loadSelect_n     <= ld;
    modePickBitInput <= si;
    writeClock       <= 1'b1;
    @(posedge mclk);
    writeDataBus     <= ~d;
    writeEnable_n    <= 1'b1;
    serialEnable_n   <= 1'b1;
    loadSelect_n     <= 1'b1;
    modePickBitInput <= ~si;
    writeClock       <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // one read edge, optionally with rewind or offset access
  task automatic rd(input logic ren, input logic ld, input logic rt);
    @(posedge mclk);
    readEnable_n <= ren;
    loadSelect_n <= ld;
    rewindRead_n <= rt;
    readClock    <= 1'b1;
    @(posedge mclk);
    readEnable_n <= 1'b1;
    loadSelect_n <= 1'b1;
    rewindRead_n <= 1'b1;
    readClock    <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // mode pin and load select held steady across the whole reset
  task automatic master_reset(input logic mode, input logic ld);
    @(posedge mclk);
    modePickBitInput <= mode;
    loadSelect_n     <= ld;
    masterReset_n    <= 1'b0;
    repeat (2) @(posedge mclk);
    masterReset_n    <= 1'b1;
    @(posedge mclk);
    loadSelect_n     <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic partial_reset();
    @(posedge mclk);
    partialReset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    partialReset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask
endmodule // dcff_port_model

/* File: dual_clock_fifo_with_flags_tb_top.sv */
// dual_clock_fifo_with_flags_tb_top: self-checking bench for the fifo
`timescale 1ns/1ns
module dual_clock_fifo_with_flags_tb_top;
  import dcff_pkg::*;
  // shallow memory keeps fill and wrap scenarios short
  localparam int DEPTH = 16;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              outputEnable_n = 1'b0;
  logic              wClk, rClk, wEn_n, rEn_n, sEn_n, ld_n, mode, mRst_n, pRst_n, rt_n;
  logic [DATA_W-1:0] wData, readDataBus;
  logic              readDataDrive;
  dcff_flags_t       flags_n;
  int                errCount = 0;
  int                cmpCount = 0;

  always #10 mclk = ~mclk;

  dcff_fifo #(.DEPTH(DEPTH)) u_dcff_fifo (
    .mclk(mclk), .rst(rst), .writeClock(wClk), .readClock(rClk),
    .writeDataBus(wData), .writeEnable_n(wEn_n), .readEnable_n(rEn_n),
    .serialEnable_n(sEn_n), .loadSelect_n(ld_n), .modePickBitInput(mode),
    .masterReset_n(mRst_n), .partialReset_n(pRst_n), .rewindRead_n(rt_n),
    .outputEnable_n(outputEnable_n), .readDataBus(readDataBus),
    .readDataDrive(readDataDrive), .flags_n(flags_n));

  dcff_port_model u_dcff_port_model (
    .mclk(mclk), .writeClock(wClk), .readClock(rClk), .writeDataBus(wData),
    .writeEnable_n(wEn_n), .readEnable_n(rEn_n), .serialEnable_n(sEn_n),
    .loadSelect_n(ld_n), .modePickBitInput(mode), .masterReset_n(mRst_n),
    .partialReset_n(pRst_n), .rewindRead_n(rt_n));

  function automatic logic [DATA_W-1:0] dat(input int i);
    return 18'h2C3A0 ^ DATA_W'(i);
  endfunction

  task automatic chk(input string nm, input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // flags order: fullSpace emptyValid almostFull almostEmpty halfFull
  task automatic chkf(input logic [4:0] mask, input logic [4:0] exp);
    chk("flags", {13'h0000, flags_n & mask}, {13'h0000, exp});
  endtask

  // flags follow synchronised pointers, so let them settle
  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic rdChk(input int first, input int n);
    for (int i = 0; i < n; i++)
    begin
      u_dcff_port_model.rd(1'b0, 1'b1, 1'b1);
      chk("word", readDataBus, dat(first + i));
    end
  endtask

  task automatic wrN(input int first, input int n);
    for (int i = 0; i < n; i++)
      u_dcff_port_model.wr(dat(first + i), 1'b0, 1'b1, 1'b1, 1'b0);
  endtask

  // offset readback: empty offset first, then full offset
  task automatic offChk(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] f);
    u_dcff_port_model.rd(1'b0, 1'b0, 1'b1);
    chk("emptyOffset", readDataBus, e);
    u_dcff_port_model.rd(1'b0, 1'b0, 1'b1);
    chk("fullOffset", readDataBus, f);
  endtask

  task automatic tParallel();
    u_dcff_port_model.master_reset(1'b0, 1'b0);
    chk("busAfterReset", readDataBus, 18'h00000);
    chkf(5'h18, 5'h10);
    offChk(18'h0007F, 18'h0007F);
    u_dcff_port_model.wr(18'h00004, 1'b0, 1'b1, 1'b0, 1'b0);
    u_dcff_port_model.wr(18'h00003, 1'b0, 1'b1, 1'b0, 1'b0);
    offChk(18'h00004, 18'h00003);
    settle();
    chkf(5'h1F, 5'h15);
  endtask

  task automatic tStandard();
    wrN(0, 10);
    settle();
    chkf(5'h1F, 5'h1E);
    // bus still stands at the last offset read, not at the first word
    chk("noEarlyWord", readDataBus, 18'h00003);
    rdChk(0, 10);
    settle();
    chkf(5'h1F, 5'h15);
    u_dcff_port_model.rd(1'b0, 1'b1, 1'b1);
    chk("emptyRead", readDataBus, dat(9));
  endtask

  task automatic tFull();
    wrN(32, 17);
    settle();
    chkf(5'h1F, 5'h0A);
    rdChk(32, 16);
    settle();
    chkf(5'h1F, 5'h15);
  endtask

  task automatic tPartialRewind();
    wrN(48, 3);
    u_dcff_port_model.partial_reset();
    settle();
    chk("busAfterPrs", readDataBus, 18'h00000);
    chkf(5'h1F, 5'h15);
    offChk(18'h00004, 18'h00003);
    wrN(64, 3);
    settle();
    chkf(5'h1F, 5'h1D);
    rdChk(64, 3);
    u_dcff_port_model.rd(1'b1, 1'b1, 1'b0);
    // hold still running: empty forced low, writes shown as blocked
    chkf(5'h18, 5'h00);
    settle();
    chkf(5'h08, 5'h08);
    rdChk(64, 3);
  endtask

  task automatic tFallThrough();
    logic [33:0] bits;
    bits = {17'h00003, 17'h00004};
    u_dcff_port_model.master_reset(1'b1, 1'b1);
    offChk(18'h003FF, 18'h003FF);
    for (int i = 33; i >= 0; i--)
      u_dcff_port_model.wr(dat(i), 1'b1, 1'b0, 1'b0, bits[i]);
    offChk(18'h00004, 18'h00003);
    settle();
    chkf(5'h18, 5'h08);
    u_dcff_port_model.wr(dat(99), 1'b0, 1'b1, 1'b1, 1'b0);
    settle();
    repeat (3) u_dcff_port_model.rd(1'b1, 1'b1, 1'b1);
    chk("fallThroughWord", readDataBus, dat(99));
    chkf(5'h18, 5'h00);
    // an enabled read consumes the word and refills at the same edge
    u_dcff_port_model.wr(dat(100), 1'b0, 1'b1, 1'b1, 1'b0);
    settle();
    u_dcff_port_model.rd(1'b0, 1'b1, 1'b1);
    chk("fallThroughNext", readDataBus, dat(100));
    u_dcff_port_model.rd(1'b0, 1'b1, 1'b1);
    chk("drainedBus", readDataBus, dat(100));
    chkf(5'h18, 5'h08);
  endtask

  task automatic tOutputEnable();
    @(posedge mclk);
    outputEnable_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("driveOff", {17'h00000, readDataDrive}, 18'h00000);
    @(posedge mclk);
    outputEnable_n <= 1'b0;
    #1;
    chk("driveOn", {17'h00000, readDataDrive}, 18'h00001);
  endtask

  task automatic endOfTest();
    $display("errors %0d comparisons %0d", errCount, cmpCount);
    if (errCount == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog sized well above the several hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    errCount++;
    endOfTest();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    tParallel();
    tStandard();
    tFull();
    tPartialRewind();
    tOutputEnable();
    tFallThrough();
    endOfTest();
  end
endmodule // dual_clock_fifo_with_flags_tb_top
